/* hdl/gpb_sync.sv */
`timescale 1ns/1ps
`include "gpb_defs.svh"
module gpb_sync
    import gpb_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    input  wire logic             i_clock,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    logic [WIDTH-1:0] nxt_meta;
    logic [WIDTH-1:0] nxt_sync;

    initial
    begin
        if (WIDTH < 1) $error("gpb_sync width must be positive.");
    end

    // R19 two flop synchroniser; the first stage feeds only the second.
    always_comb
    begin
        nxt_meta = i_async;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign o_sync = sync_ff;
endmodule : gpb_sync

/* hdl/gpb_top.sv */
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`include "gpb_defs.svh"
module gpb_top
    import gpb_pkg::*;
#(
    parameter int B_WIDTH = 8,
    parameter int C_WIDTH = 6,
    parameter int D_WIDTH = 8
)
(
    input  wire logic               i_clock,
    input  wire logic               i_rst,
    input  wire logic               i_psel,
    input  wire logic               i_penable,
    input  wire logic               i_pwrite,
    input  wire logic [11:0]        i_paddr,
    input  wire logic [31:0]        i_pwdata,
    output logic      [31:0]        o_prdata,
    output logic                    o_pready,
    output logic                    o_pslverr,
    input  wire logic [7:0]         i_converter_channel_pin,
    input  wire logic [B_WIDTH-1:0] i_port_b_pin,
    output logic      [B_WIDTH-1:0] o_port_b_pin,
    output logic      [B_WIDTH-1:0] o_port_b_pin_oe,
    output logic      [B_WIDTH-1:0] o_port_b_analog_sel,
    input  wire logic [C_WIDTH-1:0] i_port_c_pin,
    output logic      [C_WIDTH-1:0] o_port_c_pin,
    output logic      [C_WIDTH-1:0] o_port_c_pin_oe,
    input  wire logic [D_WIDTH-1:0] i_port_d_pin,
    output logic      [D_WIDTH-1:0] o_port_d_pin,
    output logic      [D_WIDTH-1:0] o_port_d_pin_oe,
    output logic      [D_WIDTH-1:0] o_port_d_pullup_on,
    output logic                    o_timer_a_ext_clock,
    output logic                    o_timer_b_ext_clock
);
    // ****************************************************************
    // Elaboration checks.
    // ****************************************************************
    // Port C must stay below bit 7 of its direction word, which holds the clock-out enable.
    initial
    begin
        if (B_WIDTH != 8 || D_WIDTH != 8) $error("Ports B and D must be 8 bits wide.");
        if (C_WIDTH < 3 || C_WIDTH > 7) $error("Port C needs bit 2 and room for the clock-out bit.");
    end

    // ****************************************************************
    // State.
    // ****************************************************************
    logic [B_WIDTH-1:0] port_b_latch_ff;
    logic [C_WIDTH-1:0] port_c_latch_ff;
    logic [D_WIDTH-1:0] port_d_latch_ff;
    logic [B_WIDTH-1:0] port_b_dir_ff;
    logic [C_WIDTH-1:0] port_c_dir_ff;
    logic [D_WIDTH-1:0] port_d_dir_ff;
    logic [D_WIDTH-1:0] port_d_pullup_en_ff;
    logic               clock_out_enable_ff;
    logic [2:0]         prescaler_select_a_ff;
    logic [2:0]         prescaler_select_b_ff;
    logic [31:0]        prdata_ff;
    logic               pslverr_ff;

    logic [B_WIDTH-1:0] nxt_port_b_latch;
    logic [C_WIDTH-1:0] nxt_port_c_latch;
    logic [D_WIDTH-1:0] nxt_port_d_latch;
    logic [B_WIDTH-1:0] nxt_port_b_dir;
    logic [C_WIDTH-1:0] nxt_port_c_dir;
    logic [D_WIDTH-1:0] nxt_port_d_dir;
    logic [D_WIDTH-1:0] nxt_port_d_pullup_en;
    logic               nxt_clock_out_enable;
    logic [2:0]         nxt_prescaler_select_a;
    logic [2:0]         nxt_prescaler_select_b;
    logic [31:0]        nxt_prdata;
    logic               nxt_pslverr;

    logic [B_WIDTH-1:0] b_pin_sync;
    logic [C_WIDTH-1:0] c_pin_sync;
    logic [D_WIDTH-1:0] d_pin_sync;
    logic [B_WIDTH-1:0] b_analog;
    gpb_reg_t           sel_reg;
    logic               access_edge;
    logic               setup_edge;

    // ****************************************************************
    // Pin synchronisers.
    // ****************************************************************
    // R19 pin levels synchronised.
    gpb_sync #(.WIDTH(B_WIDTH)) u_sync_b
    (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_async (i_port_b_pin),
        .o_sync  (b_pin_sync)
    );

    gpb_sync #(.WIDTH(C_WIDTH)) u_sync_c
    (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_async (i_port_c_pin),
        .o_sync  (c_pin_sync)
    );

    gpb_sync #(.WIDTH(D_WIDTH)) u_sync_d
    (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_async (i_port_d_pin),
        .o_sync  (d_pin_sync)
    );

    // ****************************************************************
    // APB decode.
    // ****************************************************************
    // The slave answers in the first access cycle, so pready is tied high by design.
    assign access_edge = i_psel & i_penable;
    // The setup edge captures read data, since address and direction are already valid there.
    assign setup_edge  = i_psel & ~i_penable;

    // Only word-aligned addresses hit a register; the rest get an error.
    always_comb
    begin
        sel_reg = GPB_R_NONE;
        if (i_paddr[1:0] == 2'h0 && i_paddr[11:6] == 6'h00)
        begin
            unique case (i_paddr[5:2])
                `GPB_IDX_B_LATCH:   sel_reg = GPB_R_BLAT;
                `GPB_IDX_C_LATCH:   sel_reg = GPB_R_CLAT;
                `GPB_IDX_D_LATCH:   sel_reg = GPB_R_DLAT;
                `GPB_IDX_B_DIR:     sel_reg = GPB_R_BDIR;
                `GPB_IDX_C_DIR:     sel_reg = GPB_R_CDIR;
                `GPB_IDX_D_DIR:     sel_reg = GPB_R_DDIR;
                `GPB_IDX_D_PULLUP:  sel_reg = GPB_R_DPULL;
                `GPB_IDX_TIMER_SEL: sel_reg = GPB_R_TSEL;
                default:            sel_reg = GPB_R_NONE;
            endcase
        end
    end

    // ****************************************************************
    // Register writes and read data.
    // ****************************************************************
    // Writes land only at the completing edge of the access phase.
    always_comb
    begin
        nxt_port_b_latch       = port_b_latch_ff;
        nxt_port_c_latch       = port_c_latch_ff;
        nxt_port_d_latch       = port_d_latch_ff;
        nxt_port_b_dir         = port_b_dir_ff;
        nxt_port_c_dir         = port_c_dir_ff;
        nxt_port_d_dir         = port_d_dir_ff;
        nxt_port_d_pullup_en   = port_d_pullup_en_ff;
        nxt_clock_out_enable   = clock_out_enable_ff;
        nxt_prescaler_select_a = prescaler_select_a_ff;
        nxt_prescaler_select_b = prescaler_select_b_ff;
        nxt_prdata             = prdata_ff;
        nxt_pslverr            = 1'b0;
        // Read data and error are decided at the setup edge, so both stand when pready is sampled.
        if (setup_edge)
        begin
            nxt_pslverr = (sel_reg == GPB_R_NONE);
        end
        if (i_psel)
        begin
            if (access_edge && i_pwrite)
            begin
                unique case (sel_reg)
                    // R07 latch writes always land.
                    GPB_R_BLAT:  nxt_port_b_latch = i_pwdata[B_WIDTH-1:0];
                    GPB_R_CLAT:  nxt_port_c_latch = i_pwdata[C_WIDTH-1:0];
                    GPB_R_DLAT:  nxt_port_d_latch = i_pwdata[D_WIDTH-1:0];
                    GPB_R_BDIR:  nxt_port_b_dir = i_pwdata[B_WIDTH-1:0];
                    // R11 clock-out enable writable.
                    GPB_R_CDIR:
                    begin
                        nxt_port_c_dir       = i_pwdata[C_WIDTH-1:0];
                        nxt_clock_out_enable = i_pwdata[`GPB_CLKOUT_BIT];
                    end
                    GPB_R_DDIR:  nxt_port_d_dir = i_pwdata[D_WIDTH-1:0];
                    GPB_R_DPULL: nxt_port_d_pullup_en = i_pwdata[D_WIDTH-1:0];
                    GPB_R_TSEL:
                    begin
                        nxt_prescaler_select_a = i_pwdata[`GPB_PS_A_LSB +: 3];
                        nxt_prescaler_select_b = i_pwdata[`GPB_PS_B_LSB +: 3];
                    end
                    GPB_R_NONE:  nxt_pslverr = 1'b1;
                endcase
            end
            else if (setup_edge && !i_pwrite)
            begin
                nxt_prdata = 32'h0000_0000;
                unique case (sel_reg)
                    // R06 latch for outputs, pin for inputs.
                    GPB_R_BLAT:  nxt_prdata[B_WIDTH-1:0] =
                                     (port_b_dir_ff & port_b_latch_ff) | (~port_b_dir_ff & b_pin_sync);
                    // R09 latch for outputs, pin for inputs.
                    GPB_R_CLAT:  nxt_prdata[C_WIDTH-1:0] =
                                     (port_c_dir_ff & port_c_latch_ff) | (~port_c_dir_ff & c_pin_sync);
                    // R15 latch for outputs, pin for inputs.
                    GPB_R_DLAT:  nxt_prdata[D_WIDTH-1:0] =
                                     (port_d_dir_ff & port_d_latch_ff) | (~port_d_dir_ff & d_pin_sync);
                    GPB_R_BDIR:  nxt_prdata[B_WIDTH-1:0] = port_b_dir_ff;
                    GPB_R_CDIR:
                    begin
                        nxt_prdata[C_WIDTH-1:0]      = port_c_dir_ff;
                        nxt_prdata[`GPB_CLKOUT_BIT]  = clock_out_enable_ff;
                    end
                    GPB_R_DDIR:  nxt_prdata[D_WIDTH-1:0] = port_d_dir_ff;
                    GPB_R_DPULL: nxt_prdata[D_WIDTH-1:0] = port_d_pullup_en_ff;
                    GPB_R_TSEL:
                    begin
                        nxt_prdata[`GPB_PS_A_LSB +: 3] = prescaler_select_a_ff;
                        nxt_prdata[`GPB_PS_B_LSB +: 3] = prescaler_select_b_ff;
                    end
                    GPB_R_NONE:  nxt_prdata = 32'h0000_0000;
                endcase
            end
        end
    end

    // R01 latches sit outside the reset branch, so no reset touches them.
    always_ff @(posedge i_clock)
    begin
        port_b_latch_ff <= nxt_port_b_latch;
        port_c_latch_ff <= nxt_port_c_latch;
        port_d_latch_ff <= nxt_port_d_latch;
        prdata_ff       <= nxt_prdata;
    end

    // Control registers with defined reset values.
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            // R05 port B inputs after reset.
            port_b_dir_ff         <= `GPB_DIR_RST;
            // R12 port C inputs after reset.
            port_c_dir_ff         <= C_WIDTH'(`GPB_DIR_RST);
            // R16 port D inputs after reset.
            port_d_dir_ff         <= `GPB_DIR_RST;
            // R11 clock-out cleared by reset.
            clock_out_enable_ff   <= `GPB_CLKOUT_RST;
            port_d_pullup_en_ff   <= `GPB_PULLUP_RST;
            prescaler_select_a_ff <= `GPB_PS_RST;
            prescaler_select_b_ff <= `GPB_PS_RST;
            pslverr_ff            <= 1'b0;
        end
        else
        begin
            port_b_dir_ff         <= nxt_port_b_dir;
            port_c_dir_ff         <= nxt_port_c_dir;
            port_d_dir_ff         <= nxt_port_d_dir;
            clock_out_enable_ff   <= nxt_clock_out_enable;
            port_d_pullup_en_ff   <= nxt_port_d_pullup_en;
            prescaler_select_a_ff <= nxt_prescaler_select_a;
            prescaler_select_b_ff <= nxt_prescaler_select_b;
            pslverr_ff            <= nxt_pslverr;
        end
    end

    // Read data and error are registered at the setup edge of a transfer.
    // They stand through the access phase, when the master samples pready high.
    assign o_prdata  = prdata_ff;
    assign o_pready  = 1'b1;
    assign o_pslverr = pslverr_ff & access_edge;

    // ****************************************************************
    // Pin drivers.
    // ****************************************************************
    // R02 converter selection forces a pin analog.
    assign b_analog            = i_converter_channel_pin[B_WIDTH-1:0];
    assign o_port_b_analog_sel = b_analog;
    // R03 R04 digital pins follow their direction bits.
    assign o_port_b_pin_oe = port_b_dir_ff & ~b_analog;
    // The latch always drives the pad; the enable alone decides whether it reaches the pin.
    assign o_port_b_pin    = port_b_latch_ff;

    // R10 system clock on port C bit 2; glitchy gating is accepted for a debug clock.
    always_comb
    begin
        o_port_c_pin_oe = port_c_dir_ff;
        o_port_c_pin    = port_c_latch_ff;
        if (clock_out_enable_ff)
        begin
            o_port_c_pin_oe[2] = 1'b1;
            o_port_c_pin[2]    = i_clock;
        end
    end

    // R04 port D output buffers.
    assign o_port_d_pin_oe    = port_d_dir_ff;
    assign o_port_d_pin       = port_d_latch_ff;
    // Pullups drop combinationally, in the same cycle as a direction bit turns on.
    // R17 R18 pullup only on inputs whose enable bit is set.
    assign o_port_d_pullup_on = port_d_pullup_en_ff & ~port_d_dir_ff;

    // The timer clocks pass the pin synchroniser, so an external clock must stay well below the bus clock.
    // R13 timer A clock from pin 6.
    assign o_timer_a_ext_clock = (prescaler_select_a_ff == `GPB_PS_EXT) & d_pin_sync[6];
    // R14 timer B clock from pin 4.
    assign o_timer_b_ext_clock = (prescaler_select_b_ff == `GPB_PS_EXT) & d_pin_sync[4];
endmodule : gpb_top

/* pkg/gpb_defs.svh */
`ifndef GPB_DEFS_SVH
`define GPB_DEFS_SVH
// How it works
// R01: Port B data latch is software read/write and no reset touches it.
// R02: A converter-selected port B pin is forced analog, overriding direction and latch.
// R03: Unselected port B pins are ordinary digital pins under direction control.
// R04: Direction bit 1 enables the pin output buffer; 0 leaves it high impedance.
// R05: Reset clears all eight port B direction bits.
// R06: Port B data read returns latch for outputs, pin level for inputs.
// R07: Data latch writes always land; writing an input pin's latch changes no read.
// R08: Software writes the latch before turning a direction bit from 0 to 1.
// R09: Port C data read returns latch for outputs, pin level for inputs.
// R10: Clock-out enable 1 drives system clock on port C bit 2; 0 is normal.
// R11: Clock-out enable is software read/write and cleared by reset.
// R12: Reset clears the six port C direction bits.
// R13: Port D pin 6 feeds timer A external clock when its prescaler select is 111.
// R14: Port D pin 4 feeds timer B external clock when its prescaler select is 111.
// R15: Port D data read returns latch for outputs, pin level for inputs.
// R16: Reset clears all eight port D direction bits.
// R17: Port D pullups act only on inputs and drop at once for outputs.
// R18: Each port D pullup enable bit connects its pullup when 1, independently.
// R19: Pin levels pass a two-stage synchroniser before the read path.

// ****************************************************************
// Register word indices; byte address is four times the index.
// ****************************************************************
`define GPB_IDX_B_LATCH   4'h1
`define GPB_IDX_C_LATCH   4'h2
`define GPB_IDX_D_LATCH   4'h3
`define GPB_IDX_B_DIR     4'h5
`define GPB_IDX_C_DIR     4'h6
`define GPB_IDX_D_DIR     4'h7
`define GPB_IDX_D_PULLUP  4'h8
`define GPB_IDX_TIMER_SEL 4'h9

// ****************************************************************
// Field positions and reset values.
// ****************************************************************
`define GPB_CLKOUT_BIT    7
`define GPB_PS_A_LSB      0
`define GPB_PS_B_LSB      4
`define GPB_PS_EXT        3'h7
`define GPB_DIR_RST       8'h00
`define GPB_CLKOUT_RST    1'h0
`define GPB_PULLUP_RST    8'h00
`define GPB_PS_RST        3'h0
`define GPB_SYNC_STAGES   2
`endif

/* pkg/gpb_pkg.sv */
package gpb_pkg;
    // Decoded register selected by the current APB address.
    typedef enum logic [8:0] {
        GPB_R_NONE  = 9'h001,
        GPB_R_BLAT  = 9'h002,
        GPB_R_CLAT  = 9'h004,
        GPB_R_DLAT  = 9'h008,
        GPB_R_BDIR  = 9'h010,
        GPB_R_CDIR  = 9'h020,
        GPB_R_DDIR  = 9'h040,
        GPB_R_DPULL = 9'h080,
        GPB_R_TSEL  = 9'h100
    } gpb_reg_t;
endpackage : gpb_pkg

/* test/gpb_checker.sv */
`timescale 1ns/1ps
module gpb_checker
#(
    parameter int B_WIDTH = 8,
    parameter int C_WIDTH = 6,
    parameter int D_WIDTH = 8
)
(
    input wire logic               i_clock,
    input wire logic               i_rst,
    input wire logic               i_psel,
    input wire logic               i_penable,
    input wire logic               i_pwrite,
    input wire logic [11:0]        i_paddr,
    input wire logic [31:0]        i_pwdata,
    input wire logic [31:0]        o_prdata,
    input wire logic [7:0]         i_converter_channel_pin,
    input wire logic [B_WIDTH-1:0] i_port_b_pin,
    input wire logic [B_WIDTH-1:0] o_port_b_pin,
    input wire logic [B_WIDTH-1:0] o_port_b_pin_oe,
    input wire logic [B_WIDTH-1:0] o_port_b_analog_sel,
    input wire logic [C_WIDTH-1:0] o_port_c_pin_oe,
    input wire logic [D_WIDTH-1:0] i_port_d_pin,
    input wire logic [D_WIDTH-1:0] o_port_d_pin_oe,
    input wire logic [D_WIDTH-1:0] o_port_d_pullup_on,
    input wire logic               o_timer_a_ext_clock,
    input wire logic               o_timer_b_ext_clock
);
    // ****************************************
    // Port rules seen from the pins and bus.
    // ****************************************
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);

    // Bus steps that touch the port B data word.
    sequence s_wr_b;
        i_psel && i_penable && i_pwrite && i_paddr == 12'h004;
    endsequence
    sequence s_rd_b;
        i_psel && i_penable && !i_pwrite && i_paddr == 12'h004 && i_converter_channel_pin == 8'h00;
    endsequence

    a_analog_copy: assert property (o_port_b_analog_sel == i_converter_channel_pin)
        else $error("analog select differs from channel select");
    a_analog_no_drive: assert property ((o_port_b_pin_oe & i_converter_channel_pin) == 8'h00)
        else $error("analog pin still driven");
    a_pullup_out_off: assert property ((o_port_d_pullup_on & o_port_d_pin_oe) == '0)
        else $error("pullup on while pin drives");
    a_timer_a_pin: assert property (o_timer_a_ext_clock |-> $past(i_port_d_pin[6], 2))
        else $error("timer A clock not from pin 6");
    a_timer_b_pin: assert property (o_timer_b_ext_clock |-> $past(i_port_d_pin[4], 2))
        else $error("timer B clock not from pin 4");
    a_reset_inputs: assert property ($fell(i_rst) |->
        {o_port_b_pin_oe, o_port_c_pin_oe, o_port_d_pin_oe, o_port_d_pullup_on} == '0)
        else $error("pins not inputs after reset");
    a_latch_write: assert property (s_wr_b |=> o_port_b_pin == $past(i_pwdata[7:0]))
        else $error("port B latch not written");
    // The pins must rest for three edges so the two-stage synchroniser holds them.
    // Read data must already stand at the access edge, where the master takes it.
    a_read_mix: assert property ($stable(i_port_b_pin)[*3] ##0 s_rd_b |->
        o_prdata == {24'h0, (o_port_b_pin & o_port_b_pin_oe) | (i_port_b_pin & ~o_port_b_pin_oe)})
        else $error("port B read mix wrong");
endmodule : gpb_checker

bind gpb_top gpb_checker #(.B_WIDTH(B_WIDTH), .C_WIDTH(C_WIDTH), .D_WIDTH(D_WIDTH)) gpb_checker_i (
    .i_clock, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
    .i_converter_channel_pin, .i_port_b_pin, .o_port_b_pin, .o_port_b_pin_oe, .o_port_b_analog_sel,
    .o_port_c_pin_oe, .i_port_d_pin, .o_port_d_pin_oe, .o_port_d_pullup_on,
    .o_timer_a_ext_clock, .o_timer_b_ext_clock);

/* test/gpb_pins.sv */
`timescale 1ns/1ps
module gpb_pins
#(
    parameter int W = 8
)
(
    input  wire logic         i_clock,
    input  wire logic [W-1:0] i_out,
    input  wire logic [W-1:0] i_oe,
    input  wire logic [W-1:0] i_pull,
    input  wire logic [W-1:0] i_ext,
    input  wire logic [W-1:0] i_ext_en,
    output logic      [W-1:0] o_wire
);
    // ****************************************
    // Board side of one port.
    // ****************************************
    logic tog_ff = 1'b0;

    // A floating line flips every cycle, so nobody can rely on a stale level.
    always_ff @(posedge i_clock)
        tog_ff <= ~tog_ff;

    assign o_wire = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext) | (~i_oe & ~i_ext_en & (i_pull | {W{tog_ff}}));
endmodule : gpb_pins

/* test/multi_port_gpio_bcd_tb.sv */
`timescale 1ns/1ps
module multi_port_gpio_bcd_tb;
    // ****************************************
    // Stimulus, pins and read-data scoreboard.
    // ****************************************
    logic        i_clock = 1'b0, i_rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, lb;
    logic [7:0]  chan = 8'h00, xb = 8'h00, xd = 8'h00, ed = 8'hFF, eb = 8'hFF, pb = 8'h00;
    logic [5:0]  xc = 6'h00, ec = 6'h3F, pc = 6'h00;
    logic        pready, pslverr, ta, tb;
    wire  [7:0]  bi, bo, boe, ana, di, dq, doe, dpu;
    wire  [5:0]  ci, co, coe;
    int          err_total = 0, checks_done = 0;
    logic [31:0] exp_q[$];

    // Free-running 100 MHz clock.
    initial
        forever #5 i_clock = ~i_clock;

    gpb_top gpb_top_i (.i_clock(i_clock), .i_rst(i_rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_converter_channel_pin(chan), .i_port_b_pin(bi), .o_port_b_pin(bo), .o_port_b_pin_oe(boe),
        .o_port_b_analog_sel(ana), .i_port_c_pin(ci), .o_port_c_pin(co), .o_port_c_pin_oe(coe),
        .i_port_d_pin(di), .o_port_d_pin(dq), .o_port_d_pin_oe(doe), .o_port_d_pullup_on(dpu),
        .o_timer_a_ext_clock(ta), .o_timer_b_ext_clock(tb));
    gpb_pins #(.W(8)) gpb_pins_b_i (.i_clock(i_clock), .i_out(bo), .i_oe(boe), .i_pull(pb),
        .i_ext(xb), .i_ext_en(eb), .o_wire(bi));
    gpb_pins #(.W(6)) gpb_pins_c_i (.i_clock(i_clock), .i_out(co), .i_oe(coe), .i_pull(pc),
        .i_ext(xc), .i_ext_en(ec), .o_wire(ci));
    gpb_pins #(.W(8)) gpb_pins_d_i (.i_clock(i_clock), .i_out(dq), .i_oe(doe), .i_pull(dpu),
        .i_ext(xd), .i_ext_en(ed), .o_wire(di));

    task automatic stop_test();
        if (err_total == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; the request holds until pready is seen at an edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge i_clock);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clock);
        pen <= 1'b1;
        n = 0;
        do
        begin
            @(posedge i_clock);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        psel <= 1'b0;
        pen <= 1'b0;
        if (n >= 20)
        begin
            err_total++;
            stop_test();
        end
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd

    // Latch, direction and read mix for port p; pins are driven from the board first.
    task automatic port_run(input int p);
        logic [7:0] l, m, x, k;
        l = $urandom;
        x = $urandom;
        k = (p == 1) ? 8'h3F : 8'hFF;
        m = $urandom & k;
        xb <= x;
        xc <= x[5:0];
        xd <= x;
        apb(1'b1, 12'h004 + 4 * p, l);
        rd(12'h004 + 4 * p, x & k);
        apb(1'b1, 12'h014 + 4 * p, m);
        rd(12'h004 + 4 * p, ((l & m) | (x & ~m)) & k);
        rd(12'h014 + 4 * p, m);
        #1 chk(p == 0 ? {boe, bo} : p == 1 ? {2'b0, coe, 2'b0, co} : {doe, dq}, {m, l & k});
        apb(1'b1, 12'h014 + 4 * p, 32'h0);
    endtask : port_run

    // Scoreboard: read data and error are taken at the edge that sees pready high.
    always @(posedge i_clock)
    begin
        if (psel && pen && pready === 1'b1)
        begin
            chk({31'h0, pslverr}, {31'h0, paddr > 12'h03F});
            if (!pwr)
                chk(prdata, exp_q.pop_front());
        end
    end

    initial
    begin
        void'($urandom(32'h83d3));
        repeat (16) @(posedge i_clock);
        i_rst <= 1'b0;
        #1 chk({boe, coe, doe, dpu, ta, tb}, 32'h0);
        rd(12'h014, 32'h0);
        rd(12'h018, 32'h0);
        rd(12'h01C, 32'h0);
        rd(12'h040, 32'h0);
        for (int p = 0; p < 3; p++)
            port_run(p);
        apb(1'b1, 12'h014, 32'hFF);
        for (int c = 0; c < 8; c++)
        begin
            @(posedge i_clock) chan <= 8'h01 << c;
            @(posedge i_clock) #1 chk({ana, boe}, {8'h01 << c, ~(8'h01 << c)});
        end
        chan <= 8'h00;
        apb(1'b1, 12'h018, 32'h84);
        @(posedge i_clock) #2 chk(co[2] & coe[2], 32'h1);
        #5 chk(co[2], 32'h0);
        rd(12'h018, 32'h84);
        apb(1'b1, 12'h018, 32'h0);
        #1 chk(coe, 32'h0);
        ed <= 8'hAA;
        xd <= 8'h00;
        apb(1'b1, 12'h020, 32'h55);
        rd(12'h00C, 32'h55);
        apb(1'b1, 12'h01C, 32'h0F);
        #1 chk(dpu, 32'h50);
        apb(1'b1, 12'h01C, 32'h0);
        ed <= 8'hFF;
        xd <= 8'h50;
        for (int s = 0; s < 8; s++)
        begin
            apb(1'b1, 12'h024, s * 17);
            #1 chk({ta, tb}, {2{s == 7}});
        end
        xd <= 8'h00;
        repeat (2) @(posedge i_clock);
        #1 chk({ta, tb}, 32'h0);
        lb = $urandom & 32'hFF;
        apb(1'b1, 12'h004, lb);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clock);
        i_rst <= 1'b0;
        #1 chk(boe, 32'h0);
        apb(1'b1, 12'h014, 32'hFF);
        rd(12'h004, lb);
        repeat (3) @(posedge i_clock);
        stop_test();
    end
endmodule : multi_port_gpio_bcd_tb
